/* hw/selftest_pkg.sv */
// constants shared by the power-up self-test sequencer
package selftest_pkg;
    localparam int unsigned CLK_MHZ          = 250;
    // run-bit delays
    localparam int unsigned INHIBIT_DELAY_US = 240;
    localparam int unsigned TEST_DELAY_US    = 6400;
    localparam int unsigned INHIBIT_CYCLES   = INHIBIT_DELAY_US * CLK_MHZ;
    localparam int unsigned TEST_CYCLES      = TEST_DELAY_US * CLK_MHZ;
    // master clear command and test-control bit in the first control word
    localparam logic [15:0] MCLR_CMD         = 16'h4000;
    localparam int unsigned TEST_CTL_BIT     = 13;
    localparam int unsigned MCLR_BIT         = 14;
    // result byte codes
    localparam logic [7:0]  RES_COMPLETE     = 8'h80;
    localparam logic [7:0]  RES_INHIBITED    = 8'h40;
    localparam logic [7:0]  RES_PROC_FAIL    = 8'h01;
    localparam logic [7:0]  RES_LINE_FAIL    = 8'h02;
    localparam logic [7:0]  RES_NONE         = 8'h00;
    // heartbeat blink half period
    localparam int unsigned BLINK_MS         = 250;
    localparam int unsigned BLINK_CYCLES     = BLINK_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {PROTO_HALT, PROTO_ISTART, PROTO_ASTART, PROTO_RUN} proto_state_t;
endpackage

/* hw/sync_link_power_up_self_test.sv */
// power-up and master-clear self-test sequencer with maintenance indicators
`timescale 1ns/1ns
`default_nettype none

// What this block does
// (R01) host writes master clear, polls run bit
// (R02) enabled self-test runs at power-up and clear
// (R03) enable when control bit matches switch
// (R04) run bit about 240 us when disabled
// (R05) run bit about 6.4 ms when test passes
// (R06) result byte 200/100 with run, 001/002 failed
// (R07) host reads result byte after 6.4 ms timeout
// (R08) heartbeat off at clear or with no valid state, on halt, blinks otherwise
// (R09) rts indicator lights while waiting clear-to-send
// (R10) carrier and signal-quality indicators follow carrier
// (R11) data indicators light on marking line
// (R12) result and run bit hold until next clear
module sync_link_power_up_self_test
    import selftest_pkg::*;
#(
    parameter int unsigned INHIBIT_CNT = INHIBIT_CYCLES,
    parameter int unsigned TEST_CNT    = TEST_CYCLES,
    parameter int unsigned BLINK_CNT   = BLINK_CYCLES
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // host write of the first control word
    input  wire logic        ctl_wr,
    input  wire logic [15:0] ctl_wdata,
    // board switch and microdiagnostic verdicts (pins)
    input  wire logic        self_test_switch,
    input  wire logic        proc_test_fail,
    input  wire logic        line_test_fail,
    // line and protocol status
    input  wire logic        carrier_in,
    input  wire logic        rx_line,
    input  wire logic        tx_line,
    input  wire logic        xmit_ready,
    input  wire logic        cts_in,
    input  wire logic [1:0]  proto_state,
    input  wire logic        proto_valid,
    // host-visible status
    output logic             run_bit,
    output logic [7:0]       test_result_byte,
    output logic             test_enabled,
    // indicators
    output logic             led_heartbeat,
    output logic             led_rts,
    output logic             led_carrier,
    output logic             led_sig_quality,
    output logic             led_rx_data,
    output logic             led_tx_data
);
    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    logic [5:0] meta_ff;
    logic [5:0] sync_ff;
    wire  [5:0] pins = {self_test_switch, proc_test_fail, line_test_fail,
                        carrier_in, rx_line, tx_line};
    always_ff @(posedge clk)
    begin
        meta_ff <= pins;
        sync_ff <= meta_ff;
    end
    wire sw_s      = sync_ff[5];
    wire pfail_s   = sync_ff[4];
    wire lfail_s   = sync_ff[3];
    wire carrier_s = sync_ff[2];
    wire rx_s      = sync_ff[1];
    wire tx_s      = sync_ff[0];

    //------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------
    typedef enum logic [1:0] {ST_CLEAR, ST_WAIT, ST_DONE} seq_t;
    seq_t        seq_ff, nxt_seq;
    logic [31:0] cnt_ff, nxt_cnt;
    logic        ctl_bit_ff, nxt_ctl_bit;
    logic        en_ff, nxt_en;
    logic        run_ff, nxt_run;
    logic [7:0]  res_ff, nxt_res;

    // the control bit is captured with the clear, the switch at sequencer start
    wire mclr_req  = ctl_wr & ctl_wdata[MCLR_BIT];
    wire en_decode = ctl_bit_ff ^ ~sw_s;                          // R03
    wire [31:0] target = en_ff ? TEST_CNT : INHIBIT_CNT;
    wire        cnt_done = (cnt_ff >= target - 32'd1);

    always_comb
    begin
        nxt_seq     = seq_ff;
        nxt_cnt     = cnt_ff;
        nxt_ctl_bit = ctl_bit_ff;
        nxt_en      = en_ff;
        nxt_run     = run_ff;
        nxt_res     = res_ff;
        if (mclr_req)
        begin
            nxt_seq     = ST_CLEAR;                               // R02
            nxt_ctl_bit = ctl_wdata[TEST_CTL_BIT];                // R03
            nxt_run     = 1'b0;
            nxt_res     = RES_NONE;
            nxt_cnt     = '0;
        end
        else
        begin
            case (seq_ff)
                ST_CLEAR:
                begin
                    nxt_en  = en_decode;                          // R03
                    nxt_cnt = '0;
                    nxt_seq = ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (en_ff && (pfail_s || lfail_s))
                    begin
                        // a failed test never raises the run bit
                        nxt_res = pfail_s ? RES_PROC_FAIL : RES_LINE_FAIL; // R06
                        nxt_seq = ST_DONE;
                    end
                    else if (cnt_done)
                    begin
                        nxt_run = 1'b1;                           // R04 R05
                        nxt_res = en_ff ? RES_COMPLETE : RES_INHIBITED; // R06
                        nxt_seq = ST_DONE;
                    end
                    else
                        nxt_cnt = cnt_ff + 32'd1;
                end
                ST_DONE: ;                                        // R12
                default: nxt_seq = ST_CLEAR;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            // power-up behaves as a clear with the control bit low
            seq_ff     <= ST_CLEAR;                               // R02
            cnt_ff     <= '0;
            ctl_bit_ff <= 1'b0;
            en_ff      <= 1'b0;
            run_ff     <= 1'b0;
            res_ff     <= RES_NONE;
        end
        else
        begin
            seq_ff     <= nxt_seq;
            cnt_ff     <= nxt_cnt;
            ctl_bit_ff <= nxt_ctl_bit;
            en_ff      <= nxt_en;
            run_ff     <= nxt_run;
            res_ff     <= nxt_res;
        end
    end
    assign run_bit          = run_ff;
    assign test_result_byte = res_ff;
    assign test_enabled     = en_ff;

    //------------------------------------------------------------
    // indicators
    //------------------------------------------------------------
    logic [31:0] blink_cnt_ff;
    logic        blink_ff;
    logic        hb_ff, rts_ff, car_ff, sq_ff, rxd_ff, txd_ff;
    wire         blink_tick = (blink_cnt_ff >= BLINK_CNT - 32'd1);
    // heartbeat stays dark until the protocol engine reports a state
    wire         hb_next = !proto_valid ? 1'b0 :
                           (proto_state == PROTO_HALT) ? 1'b1 : blink_ff; // R08

    always_ff @(posedge clk)
    begin
        if (srst || mclr_req)
        begin
            blink_cnt_ff <= '0;
            blink_ff     <= 1'b0;
            hb_ff        <= 1'b0;                                 // R08
        end
        else
        begin
            blink_cnt_ff <= blink_tick ? 32'd0 : blink_cnt_ff + 32'd1;
            blink_ff     <= blink_tick ? ~blink_ff : blink_ff;
            hb_ff        <= hb_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rts_ff <= 1'b0;
            car_ff <= 1'b0;
            sq_ff  <= 1'b0;
            rxd_ff <= 1'b0;
            txd_ff <= 1'b0;
        end
        else
        begin
            rts_ff <= xmit_ready & ~cts_in;                       // R09
            car_ff <= carrier_s;                                  // R10
            sq_ff  <= carrier_s;                                  // R10
            rxd_ff <= rx_s;                                       // R11
            txd_ff <= tx_s;                                       // R11
        end
    end
    assign led_heartbeat   = hb_ff;
    assign led_rts         = rts_ff;
    assign led_carrier     = car_ff;
    assign led_sig_quality = sq_ff;
    assign led_rx_data     = rxd_ff;
    assign led_tx_data     = txd_ff;

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    property p_run_clear_on_mclr;
        @(posedge clk) disable iff (srst) mclr_req |=> !run_bit [*2];
    endproperty
    a_run_clear_on_mclr: assert property (p_run_clear_on_mclr) // R02
        else $error("run bit set too soon after clear");

    property p_en_decode;
        @(posedge clk) disable iff (srst)
        (seq_ff == ST_CLEAR && !mclr_req) |=> (en_ff == $past(en_decode));
    endproperty
    a_en_decode: assert property (p_en_decode) // R03
        else $error("enable not decoded from control bit and switch");

    property p_run_codes;
        @(posedge clk) disable iff (srst)
        $rose(run_bit) |-> (test_result_byte == RES_COMPLETE ||
                            test_result_byte == RES_INHIBITED);
    endproperty
    a_run_codes: assert property (p_run_codes) // R06
        else $error("run bit without pass code");

    property p_fail_no_run;
        @(posedge clk) disable iff (srst)
        (test_result_byte == RES_PROC_FAIL || test_result_byte == RES_LINE_FAIL)
            |-> !run_bit;
    endproperty
    a_fail_no_run: assert property (p_fail_no_run) // R06
        else $error("run bit with failure code");

    property p_run_timing;
        @(posedge clk) disable iff (srst)
        $rose(run_bit) |-> ($past(cnt_ff) == target - 32'd1);
    endproperty
    a_run_timing: assert property (p_run_timing) // R04
        else $error("run bit at wrong count");

    property p_hold;
        @(posedge clk) disable iff (srst)
        (seq_ff == ST_DONE && !mclr_req) |=> $stable(test_result_byte) && $stable(run_bit);
    endproperty
    a_hold: assert property (p_hold) // R12
        else $error("result changed without clear");

    property p_hb_halt;
        @(posedge clk) disable iff (srst)
        (proto_valid && proto_state == PROTO_HALT && !mclr_req) [*2] |-> led_heartbeat;
    endproperty
    a_hb_halt: assert property (p_hb_halt) // R08
        else $error("heartbeat not steady in halt");

    property p_hb_clear;
        @(posedge clk) disable iff (srst) mclr_req |=> !led_heartbeat;
    endproperty
    a_hb_clear: assert property (p_hb_clear) // R08
        else $error("heartbeat lit at clear");

    property p_rts;
        @(posedge clk) disable iff (srst) !$past(srst) |-> led_rts == $past(xmit_ready & ~cts_in);
    endproperty
    a_rts: assert property (p_rts) // R09
        else $error("rts indicator wrong");

    property p_carrier;
        @(posedge clk) disable iff (srst) led_sig_quality == led_carrier;
    endproperty
    a_carrier: assert property (p_carrier) // R10
        else $error("signal quality differs from carrier");

    property p_rx_mark;
        @(posedge clk) disable iff (srst) rx_line [*4] |-> led_rx_data;
    endproperty
    a_rx_mark: assert property (p_rx_mark) // R11
        else $error("rx indicator dark on mark");

    c_pass:    cover property (@(posedge clk) $rose(run_bit) && test_enabled);
    c_inhibit: cover property (@(posedge clk) $rose(run_bit) && !test_enabled);
    c_fail:    cover property (@(posedge clk) test_result_byte == RES_LINE_FAIL);
    c_blink:   cover property (@(posedge clk) $rose(led_heartbeat) && proto_state == PROTO_RUN);
endmodule

`default_nettype wire

/* test/host_model.sv */
// host model: writes the control word and polls the run bit
`timescale 1ns/1ns
`default_nettype none
module host_model
    import selftest_pkg::*;
(
    // clock
    input  wire logic        clk,
    // control word write and run bit
    output logic             ctl_wr,
    output logic [15:0]      ctl_wdata,
    input  wire logic        run_bit
);
    initial
    begin
        ctl_wr    = 1'b0;
        ctl_wdata = 16'h0000;
    end

    // one-cycle write; data is scrambled afterwards so nothing leans on it
    task automatic write_ctl(input logic [15:0] d);
        @(posedge clk);
        ctl_wr    <= 1'b1;
        ctl_wdata <= d;
        @(posedge clk);
        ctl_wr    <= 1'b0;
        ctl_wdata <= ~d;
    endtask

    // bounded poll: a failed test never raises run, so give up at the limit
    task automatic poll_run(input int limit, output int waited);
        @(posedge clk);
        #1;
        waited = 1;
        while (run_bit !== 1'b1 && waited < limit)
        begin
            @(posedge clk);
            #1;
            waited++;
        end
    endtask
endmodule
`default_nettype wire

/* test/sync_link_power_up_self_test_tb.sv */
// self-checking bench for the self-test sequencer and indicators
`timescale 1ns/1ns
`default_nettype none
module sync_link_power_up_self_test_tb;
    import selftest_pkg::*;
    localparam int IC = 20;
    localparam int TC = 50;
    logic clk, srst, ctl_wr, self_test_switch, proc_test_fail, line_test_fail;
    logic carrier_in, rx_line, tx_line, xmit_ready, cts_in, proto_valid;
    logic run_bit, test_enabled, led_heartbeat, led_rts, led_carrier;
    logic led_sig_quality, led_rx_data, led_tx_data;
    logic [15:0] ctl_wdata;
    logic [7:0]  test_result_byte;
    logic [1:0]  proto_state;
    int n_errors, check_count, cyc, w, k;

    sync_link_power_up_self_test #(.INHIBIT_CNT(IC), .TEST_CNT(TC), .BLINK_CNT(4))
    u_sync_link_power_up_self_test (.clk, .srst, .ctl_wr, .ctl_wdata, .self_test_switch,
        .proc_test_fail, .line_test_fail, .carrier_in, .rx_line, .tx_line, .xmit_ready,
        .cts_in, .proto_state, .proto_valid, .run_bit, .test_result_byte, .test_enabled,
        .led_heartbeat, .led_rts, .led_carrier, .led_sig_quality, .led_rx_data,
        .led_tx_data);
    host_model u_host_model (.clk, .ctl_wr, .ctl_wdata, .run_bit);

    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // master clear with given control bit, switch and verdict pins
    task automatic run_case(input logic b13, input logic sw, input logic pf,
                            input logic lf, input logic [7:0] res);
        int n;
        n = (b13 ^ ~sw) ? TC : IC;
        @(posedge clk);
        self_test_switch <= sw;
        proc_test_fail   <= pf;
        line_test_fail   <= lf;
        repeat (3) @(posedge clk);
        u_host_model.write_ctl(MCLR_CMD | {2'b00, b13, 13'h0000});
        u_host_model.poll_run(n + 10, w);
        chk(test_enabled, {b13 ^ ~sw});
        if (res[7] || res[6])
            chk(w >= n && w <= n + 4, 1'b1);
        chk(run_bit, res[7] | res[6]);
        chk(test_result_byte, res);
    endtask

    // ----------------------------------------
    // clock, timeout and main sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            stop_test();
        end
    end

    initial
    begin
        {srst, self_test_switch, proc_test_fail, line_test_fail} = 4'h8;
        {carrier_in, rx_line, tx_line, xmit_ready, cts_in, proto_valid} = 6'h00;
        proto_state = PROTO_HALT;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        u_host_model.poll_run(TC + 10, w);
        chk(w >= TC && w <= TC + 4, 1'b1);
        chk(test_result_byte, RES_COMPLETE);
        run_case(1'b0, 1'b0, 1'b0, 1'b0, RES_COMPLETE);
        run_case(1'b0, 1'b1, 1'b0, 1'b0, RES_INHIBITED);
        run_case(1'b1, 1'b1, 1'b0, 1'b0, RES_COMPLETE);
        run_case(1'b0, 1'b0, 1'b1, 1'b0, RES_PROC_FAIL);
        run_case(1'b0, 1'b0, 1'b0, 1'b1, RES_LINE_FAIL);
        run_case(1'b0, 1'b0, 1'b1, 1'b1, RES_PROC_FAIL);
        run_case(1'b1, 1'b0, 1'b1, 1'b1, RES_INHIBITED);
        // a write without the clear bit must leave the result alone
        u_host_model.write_ctl(16'h2000);
        repeat (3) @(posedge clk);
        #1;
        chk(test_result_byte, RES_INHIBITED);
        chk(run_bit, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            {tx_line, rx_line, carrier_in} <= i[2:0];
            {xmit_ready, cts_in} <= {i[1], i[0]};
            repeat (4) @(posedge clk);
            #1;
            chk({led_carrier, led_sig_quality}, {2{i[0]}});
            chk({led_tx_data, led_rx_data}, i[2:1]);
            chk(led_rts, i[1] & ~i[0]);
        end
        @(posedge clk);
        proto_valid <= 1'b1;
        for (int s = 1; s < 4; s++)
        begin
            @(posedge clk);
            proto_state <= s[1:0];
            repeat (4) @(posedge clk);
            k = 0;
            repeat (16)
            begin
                @(posedge clk);
                #1;
                k += int'(led_heartbeat === 1'b1);
            end
            chk(k >= 6 && k <= 10, 1'b1);
        end
        @(posedge clk);
        proto_state <= PROTO_HALT;
        repeat (4) @(posedge clk);
        #1;
        chk(led_heartbeat, 1'b1);
        u_host_model.write_ctl(MCLR_CMD);
        k = 0;
        repeat (3)
        begin
            #1;
            k += int'(led_heartbeat === 1'b0);
            @(posedge clk);
        end
        chk(k > 0, 1'b1);
        stop_test();
    end
endmodule
`default_nettype wire
